// ==== src/scr_pkg.sv ====
// shared constants and types for the serial configuration and readback port
package scr_pkg;
    // ============================================================
    // word layout
    localparam int WORD_W = 32;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 5;
    localparam int SEL_W = 3;
    localparam logic [4:0] ADDR_REG1 = 5'h09;
    localparam logic [4:0] ADDR_REG2 = 5'h0A;
    localparam logic [4:0] ADDR_RDCMD = 5'h08;
    localparam logic [2:0] SEL_NONE = 3'h4;
    localparam logic [2:0] SEL_REG0 = 3'h0;
    localparam logic [2:0] SEL_REG1 = 3'h1;
    localparam logic [2:0] SEL_REG2 = 3'h2;
    localparam int RD_SEL_LSB = 28;
    localparam int RD_FLAG_BIT = 31;
    localparam int RB_BITS = 32;
    // ============================================================
    // power_gain_filter_setup fields
    localparam int R1_MIX_PD = 5;
    localparam int R1_BUF_PD = 7;
    localparam int R1_FILT_PD = 8;
    localparam int R1_CAL_PD = 10;
    localparam int R1_GAIN_LSB = 12;
    localparam logic [4:0] GAIN_MAX = 5'h18;
    localparam int R1_CORNER_LSB = 17;
    localparam int R1_DET_RES = 25;
    localparam int R1_DET_CAP = 26;
    localparam int R1_FAST_EN = 27;
    localparam int R1_FAST_X2 = 28;
    localparam int R1_OSC_TEST = 29;
    localparam int R1_ATTN = 31;
    localparam logic [31:0] R1_RESET = 32'h0100_FC89;
    // ============================================================
    // offset_calibration_setup fields
    localparam int R2_AUTOCAL = 5;
    localparam int R2_IDAC_LSB = 6;
    localparam int R2_QDAC_LSB = 14;
    localparam int R2_CAL_SEL = 24;
    localparam int R2_DIV_LSB = 25;
    localparam int R2_CLK_SEL = 28;
    localparam logic [31:0] R2_RESET = 32'h71E0_200A;
    localparam logic [7:0] DAC_RESET = 8'h80;
    // ============================================================
    // offset_dac_and_version_readback layout
    localparam int R0_ID_LSB = 5;
    localparam int R0_Q_LSB = 16;
    localparam int R0_I_LSB = 24;
    // ============================================================
    // calibration divide ratios, codes 0..7
    localparam logic [14:0] DIV_R0 = 15'h0001;
    localparam logic [14:0] DIV_R1 = 15'h0008;
    localparam logic [14:0] DIV_R2 = 15'h0010;
    localparam logic [14:0] DIV_R3 = 15'h0080;
    localparam logic [14:0] DIV_R4 = 15'h0100;
    localparam logic [14:0] DIV_R5 = 15'h0400;
    localparam logic [14:0] DIV_R6 = 15'h0800;
    localparam logic [14:0] DIV_R7 = 15'h412C;
    // ============================================================
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int OSC_HZ = 900000;
    localparam int OSC_HALF = CLK_HZ / (2 * OSC_HZ);
    localparam int SCLK_HALF = 8;
    // ============================================================
    // controller register map
    localparam logic [3:0] HOFF_WORD = 4'h0;
    localparam logic [3:0] HOFF_CTRL = 4'h4;
    localparam logic [3:0] HOFF_STAT = 4'h8;
    localparam logic [3:0] HOFF_RDATA = 4'hC;
    localparam int HCTRL_WRITE = 0;
    localparam int HCTRL_READ = 1;
    localparam int HCTRL_SEL_LSB = 4;
    typedef enum logic [2:0] {
        SCR_IDLE,
        SCR_SHIFT,
        SCR_STROBE,
        SCR_GAP,
        SCR_RDCLK
    } scr_hstate_t;
endpackage

// ==== src/scr_link_if.sv ====
// three-wire programming link plus readback pin between controller and device
`timescale 1ns/100ps
interface scr_link_if;
    logic sclk;
    logic sdata;
    logic latch_enable_pulse;
    logic readback;
    modport dev (
        input sclk,
        input sdata,
        input latch_enable_pulse,
        output readback
    );
    modport host (
        output sclk,
        output sdata,
        output latch_enable_pulse,
        input readback
    );
endinterface

// ==== src/scr_device.sv ====
// device end: shift register, configuration registers, calibration, readback
`timescale 1ns/100ps
// Operation
// - 32-bit shift register fed from data line
// - words arrive LSB first, sampled on rising clock
// - strobe rise copies word to addressed register
// - first shifted bits form destination address
// - select code 4 writes nothing
// - readback: command word then device shifts out
// - output changes on rising edge, LSB first
// - first clock idle, then 32 data clocks
// - readback shows calibrated or manual I and Q DAC values
// - power-down bits 5, 7, 8, 10
// - gain code bits 12-16, reset 15, max 24
// - corner code bits 17-24, reset 128
// - detector resistor bit 25, capacitor bit 26
// - fast gain enable bit 27, x2 bit 28
// - bit 29 routes oscillator to readback pin
// - attenuator bit 31, bit 11 resets high
// - bit 5 starts autocal, self-clears when done
// - I DAC code bits 6-13, reset 0x80
// - bit 24 selects manual or automatic calibration
// - bits 25-27 select calibration divide ratio
// - bit 28 selects oscillator or serial clock
module scr_device #(
    parameter logic [1:0] VERSION_ID = 2'h3, // arbitrary value
    parameter int OSC_HALF_CYC = scr_pkg::OSC_HALF
) (
    input wire logic clock,
    input wire logic srst,
    scr_link_if.dev link,
    input wire logic [7:0] cal_i_result,
    input wire logic [7:0] cal_q_result,
    output logic mixer_powerdown,
    output logic test_buffer_powerdown,
    output logic filter_powerdown,
    output logic calib_logic_powerdown,
    output logic [4:0] baseband_gain_code,
    output logic [7:0] corner_frequency_code,
    output logic detector_resistor_enable,
    output logic detector_capacitor_enable,
    output logic external_gain_step_enable,
    output logic gain_multiplier_x2,
    output logic output_attenuator_enable,
    output logic [7:0] i_offset_code,
    output logic [7:0] q_offset_code,
    output logic calib_busy
);
    typedef struct packed {
        logic [1:0] sclk_sync;
        logic sclk_prev;
        logic [1:0] sdat_sync;
        logic [1:0] stb_sync;
        logic stb_prev;
        logic [31:0] shift;
        logic [31:0] reg1;
        logic [31:0] reg2;
        logic [7:0] dac_i;
        logic [7:0] dac_q;
        logic cal_busy;
        logic [14:0] cal_cnt;
        logic [7:0] osc_cnt;
        logic osc_lvl;
        logic rb_active;
        logic rb_idle;
        logic [5:0] rb_cnt;
        logic [31:0] rb_shift;
        logic rb_pin;
    } scr_dev_state_t;

    scr_dev_state_t st;
    scr_dev_state_t next_st;

    // ============================================================
    // helpers
    function automatic logic [14:0] scr_div_ratio(input logic [2:0] code);
        case (code)
            3'h0: scr_div_ratio = scr_pkg::DIV_R0;
            3'h1: scr_div_ratio = scr_pkg::DIV_R1;
            3'h2: scr_div_ratio = scr_pkg::DIV_R2;
            3'h3: scr_div_ratio = scr_pkg::DIV_R3;
            3'h4: scr_div_ratio = scr_pkg::DIV_R4;
            3'h5: scr_div_ratio = scr_pkg::DIV_R5;
            3'h6: scr_div_ratio = scr_pkg::DIV_R6;
            default: scr_div_ratio = scr_pkg::DIV_R7;
        endcase
    endfunction

    logic sclk_rise;
    logic stb_rise;
    logic sclk_fall;
    logic osc_tick;
    logic cal_tick;
    logic [4:0] word_addr;
    logic [2:0] rd_sel;
    logic [31:0] reg0_word;
    logic [7:0] osc_last;

    // ============================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.sclk_sync = {st.sclk_sync[0], link.sclk};
        next_st.sclk_prev = st.sclk_sync[1];
        next_st.sdat_sync = {st.sdat_sync[0], link.sdata};
        next_st.stb_sync = {st.stb_sync[0], link.latch_enable_pulse};
        next_st.stb_prev = st.stb_sync[1];
        sclk_rise = st.sclk_sync[1] && !st.sclk_prev;
        stb_rise = st.stb_sync[1] && !st.stb_prev;
        sclk_fall = !st.sclk_sync[1] && st.sclk_prev;
        word_addr = st.shift[scr_pkg::ADDR_LSB +: scr_pkg::ADDR_W];
        rd_sel = st.shift[scr_pkg::RD_SEL_LSB +: scr_pkg::SEL_W];
        reg0_word = '0;
        reg0_word[scr_pkg::ADDR_LSB +: scr_pkg::ADDR_W] = scr_pkg::ADDR_RDCMD;
        reg0_word[scr_pkg::R0_ID_LSB +: 2] = VERSION_ID;
        reg0_word[scr_pkg::R0_Q_LSB +: 8] = st.dac_q;
        reg0_word[scr_pkg::R0_I_LSB +: 8] = st.dac_i;

        // shift LSB first on rising clock
        if (sclk_rise) begin
            next_st.shift = {st.sdat_sync[1], st.shift[31:1]};
        end

        osc_last = 8'(OSC_HALF_CYC - 1);
        osc_tick = 1'b0;
        if (st.osc_cnt >= osc_last) begin
            next_st.osc_cnt = 8'h00;
            next_st.osc_lvl = !st.osc_lvl;
            osc_tick = !st.osc_lvl;
        end else begin
            next_st.osc_cnt = st.osc_cnt + 8'h01;
        end
        cal_tick = st.reg2[scr_pkg::R2_CLK_SEL] ? osc_tick : sclk_rise;

        // autocal runs for the selected ratio
        if (!st.cal_busy) begin
            if (st.reg2[scr_pkg::R2_AUTOCAL] && st.reg2[scr_pkg::R2_CAL_SEL]
                    && !st.reg1[scr_pkg::R1_CAL_PD]) begin
                next_st.cal_busy = 1'b1;
                next_st.cal_cnt = 15'h0000;
            end
        end else if (cal_tick) begin
            if (st.cal_cnt == scr_div_ratio(st.reg2[scr_pkg::R2_DIV_LSB +: 3]) - 15'h0001)
                    begin
                next_st.cal_busy = 1'b0;
                next_st.dac_i = cal_i_result;
                next_st.dac_q = cal_q_result;
                next_st.reg2[scr_pkg::R2_AUTOCAL] = 1'b0;
            end else begin
                next_st.cal_cnt = st.cal_cnt + 15'h0001;
            end
        end
        if (!st.reg2[scr_pkg::R2_CAL_SEL]) begin
            next_st.dac_i = st.reg2[scr_pkg::R2_IDAC_LSB +: 8];
            next_st.dac_q = st.reg2[scr_pkg::R2_QDAC_LSB +: 8];
        end

        // idle clock, then 32 bits out
        if (st.rb_active && sclk_rise) begin
            if (st.rb_idle) begin
                next_st.rb_idle = 1'b0;
            end else if (st.rb_cnt == 6'(scr_pkg::RB_BITS)) begin
                next_st.rb_active = 1'b0;
            end else begin
                next_st.rb_pin = st.rb_shift[0];
                next_st.rb_shift = {1'b0, st.rb_shift[31:1]};
                next_st.rb_cnt = st.rb_cnt + 6'h01;
            end
        end
        // release pin once last bit is taken
        if (st.rb_active && !st.rb_idle && sclk_fall
                && st.rb_cnt == 6'(scr_pkg::RB_BITS)) begin
            next_st.rb_active = 1'b0;
        end

        if (stb_rise) begin
            next_st.rb_active = 1'b0;
            // full five-bit match; code 4 has no target
            if (word_addr == scr_pkg::ADDR_REG1) begin
                next_st.reg1 = st.shift;
            end else if (word_addr == scr_pkg::ADDR_REG2) begin
                next_st.reg2 = st.shift;
            end else if (word_addr == scr_pkg::ADDR_RDCMD && st.shift[scr_pkg::RD_FLAG_BIT])
                    begin
                next_st.rb_active = 1'b1;
                next_st.rb_idle = 1'b1;
                next_st.rb_cnt = 6'h00;
                case (rd_sel)
                    scr_pkg::SEL_REG0: next_st.rb_shift = reg0_word;
                    scr_pkg::SEL_REG1: next_st.rb_shift = st.reg1;
                    scr_pkg::SEL_REG2: next_st.rb_shift = st.reg2;
                    default: next_st.rb_shift = '0;
                endcase
            end
        end
        if (!next_st.rb_active) begin
            next_st.rb_pin = 1'b0;
        end
        if (srst) begin
            next_st = '0;
            next_st.reg1 = scr_pkg::R1_RESET;
            next_st.reg2 = scr_pkg::R2_RESET;
            next_st.dac_i = scr_pkg::DAC_RESET;
            next_st.dac_q = scr_pkg::DAC_RESET;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    // ============================================================
    // outputs
    // oscillator test routing
    assign link.readback = st.reg1[scr_pkg::R1_OSC_TEST] ? st.osc_lvl : st.rb_pin;
    assign mixer_powerdown = st.reg1[scr_pkg::R1_MIX_PD];
    assign test_buffer_powerdown = st.reg1[scr_pkg::R1_BUF_PD];
    assign filter_powerdown = st.reg1[scr_pkg::R1_FILT_PD];
    assign calib_logic_powerdown = st.reg1[scr_pkg::R1_CAL_PD];
    assign baseband_gain_code = (st.reg1[scr_pkg::R1_GAIN_LSB +: 5] > scr_pkg::GAIN_MAX) ?
        scr_pkg::GAIN_MAX : st.reg1[scr_pkg::R1_GAIN_LSB +: 5];
    assign corner_frequency_code = st.reg1[scr_pkg::R1_CORNER_LSB +: 8];
    assign detector_resistor_enable = st.reg1[scr_pkg::R1_DET_RES];
    assign detector_capacitor_enable = st.reg1[scr_pkg::R1_DET_CAP];
    assign external_gain_step_enable = st.reg1[scr_pkg::R1_FAST_EN];
    assign gain_multiplier_x2 = st.reg1[scr_pkg::R1_FAST_X2];
    assign output_attenuator_enable = st.reg1[scr_pkg::R1_ATTN];
    assign i_offset_code = st.dac_i;
    assign q_offset_code = st.dac_q;
    assign calib_busy = st.cal_busy;
endmodule

// ==== src/scr_host.sv ====
// controller end: register port, word shifter, strobe and readback capture
`timescale 1ns/100ps
module scr_host #(
    parameter int HALF = scr_pkg::SCLK_HALF
) (
    input wire logic clock,
    input wire logic srst,
    scr_link_if.host link,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    typedef struct packed {
        scr_pkg::scr_hstate_t fsm;
        logic [31:0] word;
        logic [31:0] shift;
        logic [31:0] rd_word;
        logic reading;
        logic [5:0] bits;
        logic [7:0] tmr;
        logic sclk;
        logic sdata;
        logic stb;
        logic [1:0] rb_sync;
        logic [31:0] rdata;
    } scr_host_state_t;

    scr_host_state_t st;
    scr_host_state_t next_st;
    logic half_done;
    logic [31:0] rd_cmd;

    always_comb begin
        next_st = st;
        next_st.rb_sync = {st.rb_sync[0], link.readback};
        half_done = (st.tmr == 8'(HALF - 1));
        next_st.tmr = half_done ? 8'h00 : st.tmr + 8'h01;
        rd_cmd = '0;
        rd_cmd[scr_pkg::ADDR_LSB +: scr_pkg::ADDR_W] = scr_pkg::ADDR_RDCMD;
        rd_cmd[scr_pkg::RD_SEL_LSB +: scr_pkg::SEL_W] = wdata[scr_pkg::HCTRL_SEL_LSB +: 3];
        rd_cmd[scr_pkg::RD_FLAG_BIT] = 1'b1;

        next_st.rdata = '0;
        if (rd) begin
            case (addr)
                scr_pkg::HOFF_WORD: next_st.rdata = st.word;
                scr_pkg::HOFF_STAT: next_st.rdata = {31'h0, st.fsm != scr_pkg::SCR_IDLE};
                scr_pkg::HOFF_RDATA: next_st.rdata = st.rd_word;
                default: next_st.rdata = '0;
            endcase
        end
        if (wr && addr == scr_pkg::HOFF_WORD) begin
            next_st.word = wdata;
        end

        case (st.fsm)
            scr_pkg::SCR_IDLE: begin
                next_st.tmr = 8'h00;
                next_st.bits = 6'h00;
                if (wr && addr == scr_pkg::HOFF_CTRL) begin
                    if (wdata[scr_pkg::HCTRL_READ]) begin
                        next_st.shift = rd_cmd;
                        next_st.reading = 1'b1;
                        next_st.fsm = scr_pkg::SCR_SHIFT;
                    end else if (wdata[scr_pkg::HCTRL_WRITE]) begin
                        next_st.shift = st.word;
                        next_st.reading = 1'b0;
                        next_st.fsm = scr_pkg::SCR_SHIFT;
                    end
                end
            end
            scr_pkg::SCR_SHIFT: begin
                // LSB first, data stable over rising edge
                next_st.sdata = st.shift[0];
                if (half_done) begin
                    next_st.sclk = !st.sclk;
                    if (st.sclk) begin
                        next_st.shift = {1'b0, st.shift[31:1]};
                        next_st.bits = st.bits + 6'h01;
                        if (st.bits == 6'(scr_pkg::WORD_W - 1)) begin
                            next_st.fsm = scr_pkg::SCR_STROBE;
                        end
                    end
                end
            end
            scr_pkg::SCR_STROBE: begin
                next_st.stb = 1'b1;
                next_st.sdata = 1'b0;
                if (half_done) begin
                    next_st.stb = 1'b0;
                    next_st.bits = 6'h00;
                    next_st.fsm = scr_pkg::SCR_GAP;
                end
            end
            scr_pkg::SCR_GAP: begin
                if (half_done) begin
                    next_st.fsm = st.reading ? scr_pkg::SCR_RDCLK : scr_pkg::SCR_IDLE;
                end
            end
            scr_pkg::SCR_RDCLK: begin
                // one idle pulse then 32 data pulses
                if (half_done) begin
                    next_st.sclk = !st.sclk;
                    if (st.sclk) begin
                        if (st.bits != 6'h00) begin
                            next_st.rd_word = {st.rb_sync[1], st.rd_word[31:1]};
                        end
                        next_st.bits = st.bits + 6'h01;
                        if (st.bits == 6'(scr_pkg::RB_BITS)) begin
                            next_st.fsm = scr_pkg::SCR_IDLE;
                        end
                    end
                end
            end
            default: next_st.fsm = scr_pkg::SCR_IDLE;
        endcase
        if (srst) begin
            next_st = '0;
            next_st.fsm = scr_pkg::SCR_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign link.sclk = st.sclk;
    assign link.sdata = st.sdata;
    assign link.latch_enable_pulse = st.stb;
    assign rdata = st.rdata;
endmodule

// ==== testbench/scr_link_checker.sv ====
// link checker between controller and device ends
`timescale 1ns/100ps
module scr_link_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_enable_pulse,
    input wire logic readback
);
    // ============================================================
    // shadow of shifted words and read window
    logic sclk_q, le_q, rd_win, osc_on;
    logic [31:0] sh, r1_img;
    logic [2:0] rd_sel;
    logic [5:0] rcnt;
    wire sclk_rise = sclk && !sclk_q;
    wire sclk_fall = !sclk && sclk_q;
    wire le_rise = latch_enable_pulse && !le_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            rd_win <= 1'b0;
            osc_on <= 1'b0;
            sh <= 32'h0;
            r1_img <= scr_pkg::R1_RESET;
            rd_sel <= 3'h0;
            rcnt <= 6'h00;
        end else begin
            sclk_q <= sclk;
            le_q <= latch_enable_pulse;
            if (sclk_rise) sh <= {sdata, sh[31:1]};
            if (sclk_rise && rd_win && rcnt != 6'h22) rcnt <= rcnt + 6'h01;
            // read window closes at the last bit's falling edge
            if (sclk_fall && rd_win && rcnt == 6'h21) rd_win <= 1'b0;
            if (le_rise) begin
                rcnt <= 6'h00;
                rd_win <= (sh[4:0] == scr_pkg::ADDR_RDCMD) && sh[31];
                rd_sel <= sh[30:28];
            end
            if (le_rise && sh[4:0] == scr_pkg::ADDR_REG1) begin
                r1_img <= sh;
                osc_on <= sh[29];
            end
        end
    end
    // ============================================================
    // properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    sequence s_strobe;
        latch_enable_pulse [*7] ##1 !latch_enable_pulse;
    endsequence
    sequence s_clk_high;
        sclk [*8] ##1 !sclk;
    endsequence
    reset_quiet_a: assert property (
        $fell(srst) |-> !sclk && !sdata && !latch_enable_pulse && !readback)
        else $error("link not quiet after reset");
    strobe_width_a: assert property ($rose(latch_enable_pulse) |-> s_strobe)
        else $error("strobe width wrong");
    clock_high_a: assert property ($rose(sclk) |-> s_clk_high)
        else $error("serial clock high phase wrong");
    data_hold_a: assert property ($rose(sclk) |=> $stable(sdata) [*7])
        else $error("data moved while clock high");
    strobe_idle_a: assert property (latch_enable_pulse |-> !sclk)
        else $error("clock pulsed during strobe");
    gap_low_a: assert property ($fell(latch_enable_pulse) |-> !sclk [*8])
        else $error("clock too soon after strobe");
    idle_pulse_a: assert property (rd_win && rcnt == 6'h01 |-> !readback)
        else $error("readback driven on idle clock");
    rb_bit_a: assert property (
        $fell(sclk) && rd_win && rd_sel == 3'h1 && rcnt >= 6'h02 && rcnt <= 6'h21
        |-> readback == r1_img[5'(rcnt - 6'h02)])
        else $error("readback bit wrong");
    idle_low_a: assert property ((!rd_win && !osc_on) [*6] |-> !readback)
        else $error("readback high outside read");
endmodule

// ==== testbench/tb.sv ====
// self-checking bench: controller and device ends joined over the link
`timescale 1ns/100ps
module tb;
    // ============================================================
    // signals
    localparam logic [1:0] DEV_ID = 2'h3; // arbitrary value
    localparam int LIMIT = 60000;
    localparam logic [31:0] WORD_A = 32'h9FFF_8929;
    localparam logic [31:0] WORD_B = 32'h0201_FC89;
    localparam logic [31:0] WORD_NONE = 32'hFFFF_FFEC;
    localparam logic [31:0] WORD_MAN = 32'h1029_568A;
    localparam logic [31:0] WORD_CAL = 32'h1300_002A;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] cal_i = 8'h3C;
    logic [7:0] cal_q = 8'hC3;
    logic [31:0] rdata;
    wire [21:0] cfg;
    wire [15:0] dac;
    wire busy;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    scr_link_if link ();
    scr_host u_scr_host (.clock(clock), .srst(srst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    scr_device #(.VERSION_ID(DEV_ID), .OSC_HALF_CYC(2)) u_scr_device (
        .clock(clock), .srst(srst), .link(link), .cal_i_result(cal_i), .cal_q_result(cal_q),
        .mixer_powerdown(cfg[21]), .test_buffer_powerdown(cfg[20]),
        .filter_powerdown(cfg[19]), .calib_logic_powerdown(cfg[18]),
        .baseband_gain_code(cfg[17:13]), .corner_frequency_code(cfg[12:5]),
        .detector_resistor_enable(cfg[4]), .detector_capacitor_enable(cfg[3]),
        .external_gain_step_enable(cfg[2]), .gain_multiplier_x2(cfg[1]),
        .output_attenuator_enable(cfg[0]), .i_offset_code(dac[15:8]),
        .q_offset_code(dac[7:0]), .calib_busy(busy));
    scr_link_checker u_scr_link_checker (.clock(clock), .srst(srst), .sclk(link.sclk),
        .sdata(link.sdata), .latch_enable_pulse(link.latch_enable_pulse),
        .readback(link.readback));
    // ============================================================
    // expectations and bus tasks
    function automatic logic [21:0] cfg_of(input logic [31:0] w);
        logic [4:0] g;
        g = (w[16:12] > scr_pkg::GAIN_MAX) ? scr_pkg::GAIN_MAX : w[16:12];
        return {w[5], w[7], w[8], w[10], g, w[24:17], w[25], w[26], w[27], w[28], w[31]};
    endfunction
    function automatic logic [31:0] r0_of(input logic [7:0] i, input logic [7:0] q);
        return {i, q, 9'h0, DEV_ID, scr_pkg::ADDR_RDCMD};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        s = 32'h1;
        n = 0;
        while (s[0] !== 1'b0 && n < 2000) begin
            bus_rd(scr_pkg::HOFF_STAT, s);
            n++;
        end
        check("busy", {31'h0, s[0]}, 32'h0);
    endtask
    task automatic send(input logic [31:0] w);
        bus_wr(scr_pkg::HOFF_WORD, w);
        bus_wr(scr_pkg::HOFF_CTRL, 32'h1);
        wait_idle();
    endtask
    task automatic read_back(input logic [2:0] sel, input logic [31:0] exp);
        logic [31:0] v;
        bus_wr(scr_pkg::HOFF_CTRL, 32'h2 | {25'h0, sel, 4'h0});
        wait_idle();
        bus_rd(scr_pkg::HOFF_RDATA, v);
        check("readback", v, exp);
    endtask
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            final_report();
        end
    end
    // ============================================================
    // scenarios
    initial begin
        logic [31:0] v;
        int n;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        #1;
        check("cfg", {10'h0, cfg}, {10'h0, cfg_of(scr_pkg::R1_RESET)});
        check("dac", {16'h0, dac}, {16'h0, scr_pkg::DAC_RESET, scr_pkg::DAC_RESET});
        read_back(3'h1, scr_pkg::R1_RESET);
        read_back(3'h2, scr_pkg::R2_RESET);
        read_back(3'h0, r0_of(scr_pkg::DAC_RESET, scr_pkg::DAC_RESET));
        send(WORD_B);
        check("cfg", {10'h0, cfg}, {10'h0, cfg_of(WORD_B)});
        send(WORD_NONE);
        check("cfg", {10'h0, cfg}, {10'h0, cfg_of(WORD_B)});
        read_back(3'h1, WORD_B);
        send(WORD_A);
        check("cfg", {10'h0, cfg}, {10'h0, cfg_of(WORD_A)});
        read_back(3'h1, WORD_A);
        bus_rd(scr_pkg::HOFF_WORD, v);
        check("word", v, WORD_A);
        bus_rd(4'h2, v);
        check("unmapped", v, 32'h0);
        send(WORD_MAN);
        check("dac", {16'h0, dac}, 32'h5AA5);
        read_back(3'h0, r0_of(8'h5A, 8'hA5));
        for (int c = 0; c < 8; c++) begin
            send(WORD_MAN | (32'(c) << 25));
            read_back(3'h2, WORD_MAN | (32'(c) << 25));
        end
        send(WORD_CAL);
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        check("calib", {31'h0, busy}, 32'h0);
        check("dac", {16'h0, dac}, {16'h0, cal_i, cal_q});
        read_back(3'h2, WORD_CAL & ~32'h20);
        read_back(3'h0, r0_of(cal_i, cal_q));
        send(WORD_A | 32'h2000_0000);
        n = 0;
        repeat (40) begin
            @(posedge clock);
            #1;
            n += int'(link.readback === 1'b1);
        end
        check("osc", {31'h0, n > 0 && n < 40}, 32'h1);
        send(WORD_A);
        // mid-run reset returns defaults
        @(posedge clock);
        srst <= 1'b1;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        #1;
        check("cfg", {10'h0, cfg}, {10'h0, cfg_of(scr_pkg::R1_RESET)});
        check("dac", {16'h0, dac}, {16'h0, scr_pkg::DAC_RESET, scr_pkg::DAC_RESET});
        final_report();
    end
endmodule
